// ---- rtl/tsf_pkg.sv ----
// Constants, types and register layout for the three-axis sample buffer.
// Assumes the core clock runs at 10 MHz; the serial pins are synchronised inside the sample buffer.
package tsf_pkg;

  localparam int DEPTH = 32;
  localparam int SAMPLE_W = 16;

  // Serial register map (7-bit index)
  localparam logic [6:0] ADDR_INT_PIN_CTRL = 7'h22;
  localparam logic [6:0] ADDR_SERIAL_CFG = 7'h23;
  localparam logic [6:0] ADDR_OUT_X_L = 7'h28;
  localparam logic [6:0] ADDR_OUT_Z_H = 7'h2d;
  localparam logic [6:0] ADDR_BUF_CTRL = 7'h2e;
  localparam logic [6:0] ADDR_BUF_SOURCE = 7'h2f;

  // Buffer control: mode in [7:5], watermark level in [4:0]
  localparam int CTRL_MODE_LSB = 5;
  localparam int CTRL_WTM_W = 5;
  // Buffer source status
  localparam int SRC_WTM_BIT = 7;
  localparam int SRC_FULL_BIT = 6;
  localparam int SRC_EMPTY_BIT = 5;
  // Interrupt pin control
  localparam int IPC_WTM_EN_BIT = 2;
  localparam int IPC_FULL_EN_BIT = 1;
  localparam int IPC_EMPTY_EN_BIT = 0;
  // Serial configuration
  localparam int CFG_3WIRE_BIT = 0;

  localparam logic [7:0] BUF_CTRL_RST = 8'h00;
  localparam logic [7:0] INT_PIN_CTRL_RST = 8'h00;
  localparam logic [7:0] SERIAL_CFG_RST = 8'h00;

  // Upper six bits of the two-wire slave address
  localparam logic [5:0] I2C_ADDR_HI = 6'h34;

  // Two-wire fast mode; the core samples the bus at least this many times per bit
  localparam int CORE_CLK_HZ = 10000000;
  localparam int I2C_FAST_HZ = 400000;
  localparam int I2C_SAMPLES_PER_BIT = CORE_CLK_HZ / I2C_FAST_HZ;

  typedef enum logic [2:0] {
    MODE_BYPASS = 3'h0,
    MODE_FIFO = 3'h1,
    MODE_STREAM = 3'h2,
    MODE_STREAM_TO_FIFO = 3'h3,
    MODE_BYPASS_TO_STREAM = 3'h4
  } tsf_mode_e;

  typedef enum logic [3:0] {
    I2C_IDLE = 4'h0,
    I2C_ADDR = 4'h1,
    I2C_ADDR_ACK = 4'h3,
    I2C_SUB = 4'h2,
    I2C_SUB_ACK = 4'h6,
    I2C_WR = 4'h7,
    I2C_WR_ACK = 4'h5,
    I2C_RD = 4'h4,
    I2C_RD_ACK = 4'hc
  } tsf_i2c_state_e;

  typedef struct packed {
    logic [SAMPLE_W-1:0] z;
    logic [SAMPLE_W-1:0] y;
    logic [SAMPLE_W-1:0] x;
  } tsf_sample_s;

  typedef struct packed {
    logic [6:0] addr;
    logic [7:0] data;
  } tsf_reg_wr_s;

endpackage

// ---- rtl/tsf_sample_fifo.sv ----
// Three-axis sample buffer with two-wire and four/three-wire serial register access.
// Assumes samples and the trigger come from logic on core_clk_i; serial pins are async.
// Notes on behaviour
// - Three channels, 32 entries of 16 bits
// - Five modes chosen by control mode field
// - Watermark, empty, full enable onto pin
// - Five-bit watermark, fires when level reached
// - Bypass keeps buffer empty, overwrites one entry
// - FIFO mode stops storing when full
// - Stream mode discards oldest when full
// - Bypass until trigger, then stream
// - Stream until trigger, then FIFO
// - Watermark reaches pin only when enabled
// - Reads load oldest set into outputs
// - Burst read wraps Z high to X low
// - Registers via two-wire and SPI, 3/4-wire
// - Address LSB from serial output pin
// - Two-wire slave works up to 400 kHz
// - Sub-address low seven index, top increments
// - SPI second bit enables address increment
`timescale 1ns/100ps
module tsf_sample_fifo #(
  parameter int DEPTH = tsf_pkg::DEPTH
) (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic sample_valid_i,
  input wire tsf_pkg::tsf_sample_s sample_i,
  input wire logic trigger_event_i,
  input wire logic port_sel_i,
  input wire logic serial_clk_i,
  input wire logic serial_data_i,
  input wire logic serial_out_addr_lsb_i,
  output logic serial_data_o,
  output logic serial_data_oe_o,
  output logic serial_data_spi_o,
  output logic serial_data_spi_oe_o,
  output logic serial_out_addr_lsb_o,
  output logic serial_out_addr_lsb_oe_o,
  output logic ready_or_irq2_pin_o
);
  import tsf_pkg::*;

  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = PTR_W + 1;

  logic [1:0] rst_sync_reg;
  logic rst_n;
  always_ff @(posedge core_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // Pin synchronisers; third stage only for edge detection
  logic [3:0] pin_raw, pin_s1_reg, pin_s2_reg, pin_d_reg;
  logic i2c_sel, scl_s, sda_s, lsb_s, scl_rise, scl_fall, start_c, stop_c;
  assign pin_raw = {serial_out_addr_lsb_i, serial_data_i, serial_clk_i, port_sel_i};
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 4'hf;
      pin_s2_reg <= 4'hf;
      pin_d_reg <= 4'hf;
    end else begin
      pin_s1_reg <= pin_raw;
      pin_s2_reg <= pin_s1_reg;
      pin_d_reg <= pin_s2_reg;
    end
  end
  assign i2c_sel = pin_s2_reg[0];
  assign scl_s = pin_s2_reg[1];
  assign sda_s = pin_s2_reg[2];
  assign lsb_s = pin_s2_reg[3];
  assign scl_rise = scl_s & ~pin_d_reg[1];
  assign scl_fall = ~scl_s & pin_d_reg[1];
  assign start_c = scl_s & pin_d_reg[1] & ~sda_s & pin_d_reg[2];
  assign stop_c = scl_s & pin_d_reg[1] & sda_s & ~pin_d_reg[2];

  // Register state
  logic [7:0] buf_ctrl_reg, interrupt_pin_control_reg, serial_cfg_reg, buffer_source_status_reg;
  tsf_sample_s out_reg;
  tsf_mode_e mode;
  logic [CTRL_WTM_W-1:0] watermark_level;
  logic three_wire;
  assign mode = tsf_mode_e'(buf_ctrl_reg[CTRL_MODE_LSB +: 3]);
  assign watermark_level = buf_ctrl_reg[CTRL_WTM_W-1:0];
  assign three_wire = serial_cfg_reg[CFG_3WIRE_BIT];

  function automatic logic [7:0] reg_read(input logic [6:0] a);
    logic [7:0] d;
    logic [2:0] bi;
    d = 8'h00;
    bi = 3'(a - ADDR_OUT_X_L);
    if (a >= ADDR_OUT_X_L && a <= ADDR_OUT_Z_H) begin
      d = out_reg[{bi, 3'b000} +: 8];
    end else if (a == ADDR_INT_PIN_CTRL) begin
      d = interrupt_pin_control_reg;
    end else if (a == ADDR_SERIAL_CFG) begin
      d = serial_cfg_reg;
    end else if (a == ADDR_BUF_CTRL) begin
      d = buf_ctrl_reg;
    end else if (a == ADDR_BUF_SOURCE) begin
      d = buffer_source_status_reg;
    end
    return d;
  endfunction

  function automatic logic [6:0] next_addr(input logic [6:0] a);
    return (a == ADDR_OUT_Z_H) ? ADDR_OUT_X_L : 7'(a + 7'h01);
  endfunction

  // Two-wire slave
  tsf_i2c_state_e i2c_state_reg;
  logic [3:0] i2c_cnt_reg;
  logic [7:0] i2c_sh_reg, i2c_rd_byte;
  logic [6:0] i2c_addr_reg, i2c_rd_ptr, i2c_rd_addr_reg;
  logic i2c_rw_reg, i2c_inc_reg, i2c_nack_reg, i2c_wr_valid_reg, i2c_rd_valid_reg;
  tsf_reg_wr_s i2c_wr_reg;

  always_comb begin
    i2c_rd_ptr = i2c_addr_reg;
    if (i2c_state_reg == I2C_RD_ACK && i2c_inc_reg) begin
      i2c_rd_ptr = next_addr(i2c_addr_reg);
    end
    i2c_rd_byte = reg_read(i2c_rd_ptr);
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      i2c_state_reg <= I2C_IDLE;
      i2c_cnt_reg <= 4'h0;
      i2c_sh_reg <= 8'h00;
      i2c_addr_reg <= 7'h00;
      i2c_rd_addr_reg <= 7'h00;
      i2c_rw_reg <= 1'b0;
      i2c_inc_reg <= 1'b0;
      i2c_nack_reg <= 1'b0;
      i2c_wr_valid_reg <= 1'b0;
      i2c_rd_valid_reg <= 1'b0;
      i2c_wr_reg <= '0;
      serial_data_oe_o <= 1'b0;
    end else begin
      i2c_wr_valid_reg <= 1'b0;
      i2c_rd_valid_reg <= 1'b0;
      if (!i2c_sel || stop_c) begin
        i2c_state_reg <= I2C_IDLE;
        serial_data_oe_o <= 1'b0;
      end else if (start_c) begin
        i2c_state_reg <= I2C_ADDR;
        i2c_cnt_reg <= 4'h0;
        serial_data_oe_o <= 1'b0;
      end else if (scl_rise) begin
        i2c_cnt_reg <= i2c_cnt_reg + 4'h1;
        if (i2c_state_reg != I2C_RD) begin
          i2c_sh_reg <= {i2c_sh_reg[6:0], sda_s};
        end
        if (i2c_state_reg == I2C_RD_ACK) begin
          i2c_nack_reg <= sda_s;
        end
      end else if (scl_fall) begin
        unique case (i2c_state_reg)
          I2C_IDLE: begin
          end
          I2C_ADDR: begin
            if (i2c_cnt_reg == 4'h8) begin
              if (i2c_sh_reg[7:1] == {I2C_ADDR_HI, lsb_s}) begin
                i2c_state_reg <= I2C_ADDR_ACK;
                serial_data_oe_o <= 1'b1;
                i2c_rw_reg <= i2c_sh_reg[0];
              end else begin
                i2c_state_reg <= I2C_IDLE;
              end
            end
          end
          I2C_ADDR_ACK: begin
            i2c_cnt_reg <= 4'h0;
            if (i2c_rw_reg) begin
              i2c_state_reg <= I2C_RD;
              serial_data_oe_o <= ~i2c_rd_byte[7];
              i2c_sh_reg <= {i2c_rd_byte[6:0], 1'b0};
              i2c_rd_valid_reg <= 1'b1;
              i2c_rd_addr_reg <= i2c_rd_ptr;
            end else begin
              i2c_state_reg <= I2C_SUB;
              serial_data_oe_o <= 1'b0;
            end
          end
          I2C_SUB: begin
            if (i2c_cnt_reg == 4'h8) begin
              i2c_state_reg <= I2C_SUB_ACK;
              serial_data_oe_o <= 1'b1;
              i2c_addr_reg <= i2c_sh_reg[6:0];
              i2c_inc_reg <= i2c_sh_reg[7];
            end
          end
          I2C_SUB_ACK: begin
            i2c_state_reg <= I2C_WR;
            serial_data_oe_o <= 1'b0;
            i2c_cnt_reg <= 4'h0;
          end
          I2C_WR: begin
            if (i2c_cnt_reg == 4'h8) begin
              i2c_state_reg <= I2C_WR_ACK;
              serial_data_oe_o <= 1'b1;
              i2c_wr_valid_reg <= 1'b1;
              i2c_wr_reg <= '{addr: i2c_addr_reg, data: i2c_sh_reg};
            end
          end
          I2C_WR_ACK: begin
            i2c_state_reg <= I2C_WR;
            serial_data_oe_o <= 1'b0;
            i2c_cnt_reg <= 4'h0;
            if (i2c_inc_reg) begin
              i2c_addr_reg <= next_addr(i2c_addr_reg);
            end
          end
          I2C_RD: begin
            if (i2c_cnt_reg == 4'h8) begin
              i2c_state_reg <= I2C_RD_ACK;
              serial_data_oe_o <= 1'b0;
            end else begin
              serial_data_oe_o <= ~i2c_sh_reg[7];
              i2c_sh_reg <= {i2c_sh_reg[6:0], 1'b0};
            end
          end
          I2C_RD_ACK: begin
            if (i2c_nack_reg) begin
              i2c_state_reg <= I2C_IDLE;
            end else begin
              i2c_state_reg <= I2C_RD;
              i2c_cnt_reg <= 4'h0;
              i2c_addr_reg <= i2c_rd_ptr;
              serial_data_oe_o <= ~i2c_rd_byte[7];
              i2c_sh_reg <= {i2c_rd_byte[6:0], 1'b0};
              i2c_rd_valid_reg <= 1'b1;
              i2c_rd_addr_reg <= i2c_rd_ptr;
            end
          end
        endcase
      end
    end
  end

  // Open drain: only ever pulls low
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      serial_data_o <= 1'b0;
    end else begin
      serial_data_o <= 1'b0;
    end
  end

  // SPI slave on the link clock; a high port select holds it in reset
  logic spi_rst_n;
  logic [2:0] spi_bit_reg;
  logic [7:0] spi_sh_reg, spi_sh_next, spi_tx_reg, spi_rd_byte;
  logic [5:0] spi_addr_reg;
  logic spi_cmd_done_reg, spi_rw_reg, auto_increment_flag, spi_out_bit;
  logic spi_wr_tgl_reg, spi_rd_tgl_reg;
  logic [6:0] spi_rd_addr_reg;
  tsf_reg_wr_s spi_wr_word_reg;
  assign spi_rst_n = rst_n & ~port_sel_i;
  assign spi_sh_next = {spi_sh_reg[6:0], serial_data_i};
  // Core registers are stable while a byte is shifted, so read directly
  always_comb begin
    spi_rd_byte = reg_read({1'b0, spi_addr_reg});
  end
  assign spi_out_bit = (spi_bit_reg == 3'h0) ? spi_rd_byte[7] : spi_tx_reg[7];

  always_ff @(posedge serial_clk_i or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      spi_bit_reg <= 3'h0;
      spi_sh_reg <= 8'h00;
      spi_cmd_done_reg <= 1'b0;
      spi_rw_reg <= 1'b0;
      auto_increment_flag <= 1'b0;
      spi_addr_reg <= 6'h00;
    end else begin
      spi_bit_reg <= spi_bit_reg + 3'h1;
      spi_sh_reg <= spi_sh_next;
      if (spi_bit_reg == 3'h7) begin
        if (!spi_cmd_done_reg) begin
          spi_cmd_done_reg <= 1'b1;
          spi_rw_reg <= spi_sh_next[7];
          auto_increment_flag <= spi_sh_next[6];
          spi_addr_reg <= spi_sh_next[5:0];
        end else if (auto_increment_flag) begin
          spi_addr_reg <= 6'(next_addr({1'b0, spi_addr_reg}));
        end
      end
    end
  end

  // Event toggles survive frame end; only the core reset clears them
  always_ff @(posedge serial_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      spi_wr_tgl_reg <= 1'b0;
      spi_rd_tgl_reg <= 1'b0;
      spi_rd_addr_reg <= 7'h00;
      spi_wr_word_reg <= '0;
    end else if (!port_sel_i && spi_cmd_done_reg && spi_bit_reg == 3'h7) begin
      if (spi_rw_reg) begin
        // Only Z-high reads cross, so the held index stays put until the core sees it
        if ({1'b0, spi_addr_reg} == ADDR_OUT_Z_H) begin
          spi_rd_tgl_reg <= ~spi_rd_tgl_reg;
          spi_rd_addr_reg <= {1'b0, spi_addr_reg};
        end
      end else begin
        spi_wr_tgl_reg <= ~spi_wr_tgl_reg;
        spi_wr_word_reg <= '{addr: {1'b0, spi_addr_reg}, data: spi_sh_next};
      end
    end
  end

  always_ff @(negedge serial_clk_i or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      spi_tx_reg <= 8'h00;
      serial_out_addr_lsb_o <= 1'b0;
      serial_out_addr_lsb_oe_o <= 1'b0;
      serial_data_spi_o <= 1'b0;
      serial_data_spi_oe_o <= 1'b0;
    end else if (spi_cmd_done_reg && spi_rw_reg) begin
      spi_tx_reg <= (spi_bit_reg == 3'h0) ? {spi_rd_byte[6:0], 1'b0} : {spi_tx_reg[6:0], 1'b0};
      serial_out_addr_lsb_o <= spi_out_bit;
      serial_out_addr_lsb_oe_o <= ~three_wire;
      serial_data_spi_o <= spi_out_bit;
      serial_data_spi_oe_o <= three_wire;
    end
  end

  // Toggle crossing into the core; held words are stable when seen
  logic [1:0] tgl_s1_reg, tgl_s2_reg, tgl_d_reg;
  logic spi_wr_evt, spi_rd_evt, wr_valid, rd_last;
  tsf_reg_wr_s wr_word;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      tgl_s1_reg <= 2'b00;
      tgl_s2_reg <= 2'b00;
      tgl_d_reg <= 2'b00;
    end else begin
      tgl_s1_reg <= {spi_rd_tgl_reg, spi_wr_tgl_reg};
      tgl_s2_reg <= tgl_s1_reg;
      tgl_d_reg <= tgl_s2_reg;
    end
  end
  assign spi_wr_evt = tgl_s2_reg[0] ^ tgl_d_reg[0];
  assign spi_rd_evt = tgl_s2_reg[1] ^ tgl_d_reg[1];
  assign wr_valid = spi_wr_evt | i2c_wr_valid_reg;
  assign wr_word = spi_wr_evt ? spi_wr_word_reg : i2c_wr_reg;
  assign rd_last = (spi_rd_evt && spi_rd_addr_reg == ADDR_OUT_Z_H)
                || (i2c_rd_valid_reg && i2c_rd_addr_reg == ADDR_OUT_Z_H);

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      buf_ctrl_reg <= BUF_CTRL_RST;
      interrupt_pin_control_reg <= INT_PIN_CTRL_RST;
      serial_cfg_reg <= SERIAL_CFG_RST;
    end else if (wr_valid) begin
      if (wr_word.addr == ADDR_BUF_CTRL) begin
        buf_ctrl_reg <= wr_word.data;
      end
      if (wr_word.addr == ADDR_INT_PIN_CTRL) begin
        interrupt_pin_control_reg <= wr_word.data;
      end
      if (wr_word.addr == ADDR_SERIAL_CFG) begin
        serial_cfg_reg <= wr_word.data;
      end
    end
  end

  // Trigger latch and effective mode
  logic trig_seen_reg, eff_bypass, eff_stream;
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      trig_seen_reg <= 1'b0;
    end else if (mode != MODE_STREAM_TO_FIFO && mode != MODE_BYPASS_TO_STREAM) begin
      trig_seen_reg <= 1'b0;
    end else if (trigger_event_i) begin
      trig_seen_reg <= 1'b1;
    end
  end
  always_comb begin
    eff_bypass = 1'b0;
    eff_stream = 1'b0;
    case (mode)
      MODE_FIFO: eff_stream = 1'b0;
      MODE_STREAM: eff_stream = 1'b1;
      MODE_STREAM_TO_FIFO: eff_stream = ~trig_seen_reg;
      MODE_BYPASS_TO_STREAM: begin
        eff_bypass = ~trig_seen_reg;
        eff_stream = trig_seen_reg;
      end
      default: eff_bypass = 1'b1;
    endcase
  end

  // Sample storage
  tsf_sample_s mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg, rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic full, empty, push, pop, discard, wtm_hit;
  assign full = count_reg == CNT_W'(DEPTH);
  assign empty = count_reg == '0;
  assign push = sample_valid_i & ~eff_bypass & (~full | eff_stream);
  assign pop = rd_last & ~empty & ~eff_bypass;
  assign discard = push & full & ~pop;
  assign wtm_hit = count_reg >= CNT_W'(watermark_level);

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem[wr_ptr_reg] <= sample_i;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else if (eff_bypass) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + PTR_W'(push);
      rd_ptr_reg <= rd_ptr_reg + PTR_W'(pop | discard);
      count_reg <= count_reg + CNT_W'(push) - CNT_W'(pop) - CNT_W'(discard);
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      out_reg <= '0;
    end else if (eff_bypass) begin
      if (sample_valid_i) begin
        out_reg <= sample_i;
      end
    end else if (!empty) begin
      // Outputs show the oldest entry; a stream discard may change it mid-burst
      out_reg <= mem[rd_ptr_reg];
    end
  end

  // Status frozen during an SPI frame so a burst sees one snapshot
  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      buffer_source_status_reg <= 8'h20;
      ready_or_irq2_pin_o <= 1'b0;
    end else begin
      if (i2c_sel) begin
        buffer_source_status_reg <= {wtm_hit, full, empty, 5'(count_reg)};
      end
      ready_or_irq2_pin_o <= (wtm_hit & interrupt_pin_control_reg[IPC_WTM_EN_BIT])
                           | (full & interrupt_pin_control_reg[IPC_FULL_EN_BIT])
                           | (empty & interrupt_pin_control_reg[IPC_EMPTY_EN_BIT]);
    end
  end

endmodule

// ---- tb/tsf_sample_fifo_assertions.sv ----
// Port-level checks on the serial pins and interrupt pin of the sample buffer.
// Assumes the serial clock stands high while the select pin is high.
`timescale 1ns/100ps
module tsf_sample_fifo_assertions (
  input wire logic core_clk_i,
  input wire logic rstn_i,
  input wire logic port_sel_i,
  input wire logic serial_clk_i,
  input wire logic serial_data_i,
  input wire logic serial_data_o,
  input wire logic serial_data_oe_o,
  input wire logic serial_data_spi_oe_o,
  input wire logic serial_out_addr_lsb_oe_o,
  input wire logic ready_or_irq2_pin_o
);
  logic [7:0] fall_cnt;
  logic rd_cmd;
  wire spi_oe = serial_data_spi_oe_o | serial_out_addr_lsb_oe_o;

  // Falls since select went low; saturates so long bursts stay flagged
  always_ff @(negedge serial_clk_i or posedge port_sel_i) begin
    if (port_sel_i) begin
      fall_cnt <= 8'h00;
    end else if (fall_cnt != 8'hff) begin
      fall_cnt <= fall_cnt + 8'h01;
    end
  end

  always_ff @(posedge serial_clk_i or posedge port_sel_i) begin
    if (port_sel_i) begin
      rd_cmd <= 1'b0;
    end else if (fall_cnt == 8'h01) begin
      rd_cmd <= serial_data_i;
    end
  end

  a_cmd_quiet: assert property (@(posedge serial_clk_i) disable iff (port_sel_i || !rstn_i)
    fall_cnt <= 8'h08 |-> !spi_oe) else $error("data out driven in command phase");
  a_write_quiet: assert property (@(posedge serial_clk_i) disable iff (port_sel_i || !rstn_i)
    !rd_cmd && fall_cnt > 8'h01 |-> !spi_oe) else $error("data out driven in write frame");
  a_read_drives: assert property (@(posedge serial_clk_i) disable iff (port_sel_i || !rstn_i)
    rd_cmd && fall_cnt >= 8'h09 |-> spi_oe) else $error("read data not driven");
  a_cs_release: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    $rose(port_sel_i) |-> ##[1:3] !spi_oe) else $error("spi drive kept after select rose");
  a_quiet_two_wire: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    port_sel_i [*4] |-> !spi_oe) else $error("spi drive in two-wire mode");
  a_no_ack_spi: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    (!port_sel_i) [*8] |-> !serial_data_oe_o) else $error("two-wire ack while spi selected");
  a_oe_exclusive: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    !(serial_data_oe_o && spi_oe)) else $error("two drivers on data pins");
  a_open_drain: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    serial_data_oe_o |-> !serial_data_o) else $error("shared data wire driven high");
  a_reset_quiet: assert property (@(posedge core_clk_i) disable iff (!rstn_i)
    $rose(rstn_i) |-> !ready_or_irq2_pin_o ##1 !ready_or_irq2_pin_o)
    else $error("interrupt pin high right after reset");
endmodule

bind tsf_sample_fifo tsf_sample_fifo_assertions u_chk (
  .core_clk_i(core_clk_i),
  .rstn_i(rstn_i),
  .port_sel_i(port_sel_i),
  .serial_clk_i(serial_clk_i),
  .serial_data_i(serial_data_i),
  .serial_data_o(serial_data_o),
  .serial_data_oe_o(serial_data_oe_o),
  .serial_data_spi_oe_o(serial_data_spi_oe_o),
  .serial_out_addr_lsb_oe_o(serial_out_addr_lsb_oe_o),
  .ready_or_irq2_pin_o(ready_or_irq2_pin_o)
);

// ---- tb/tsf_host_model.sv ----
// SPI host model with a 15 ns serial clock, plus a slow two-wire register writer.
// Assumes the bench resolves the shared data wire and the data-out pin.
`timescale 1ns/100ps
module tsf_host_model (
  output logic cs_o,
  output logic spc_o,
  output logic sdi_o,
  output logic sdi_en_o,
  input wire logic sdo_i,
  input wire logic sda_i
);
  initial begin
    cs_o = 1'b1;
    spc_o = 1'b1;
    sdi_o = 1'b1;
    sdi_en_o = 1'b0;
  end

  // Clock stands high outside frames; read phase releases the shared data wire
  task automatic frame(input logic rw, input logic [5:0] addr, input int nb,
                       input logic [7:0] wd, output logic [55:0] rd);
    logic [7:0] cmd;
    cmd = {rw, nb > 1, addr};
    rd = '0;
    cs_o = 1'b0;
    sdi_en_o = 1'b1;
    for (int i = 0; i < 8 * (nb + 1); i++) begin
      #7.5 spc_o = 1'b0;
      sdi_o = (i < 8) ? cmd[7 - i] : (rw ? ~sdi_o : wd[15 - i]);
      sdi_en_o = !(rw && i >= 8);
      #7.5 spc_o = 1'b1;
      rd = {rd[54:0], sdo_i & sda_i};
    end
    #7.5 cs_o = 1'b1;
    sdi_en_o = 1'b0;
  endtask

  // Two-wire single register write; the three acks come back low
  task automatic i2c_wr(input logic [6:0] dev, input logic [7:0] sub, input logic [7:0] wd,
                        output logic [2:0] ack);
    logic [26:0] bits;
    bits = {dev, 1'b0, 1'b1, sub, 1'b1, wd, 1'b1};
    sdi_o = 1'b1;
    sdi_en_o = 1'b1;
    #600 sdi_o = 1'b0;
    #600 spc_o = 1'b0;
    for (int i = 26; i >= 0; i--) begin
      #300 sdi_o = bits[i];
      #300 spc_o = 1'b1;
      if (i % 9 == 0) begin
        ack = {ack[1:0], sda_i};
      end
      #600 spc_o = 1'b0;
    end
    #300 sdi_o = 1'b0;
    #300 spc_o = 1'b1;
    #600 sdi_o = 1'b1;
    sdi_en_o = 1'b0;
  endtask
endmodule

// ---- tb/tsf_sample_fifo_tb.sv ----
// Self-checking bench for the sample buffer, reached through the SPI host model.
// Assumes a 10 MHz core clock and the default depth of 32.
`timescale 1ns/100ps
module tsf_sample_fifo_tb;
  import tsf_pkg::*;
  logic clk;
  logic rstn = 1'b0;
  logic valid = 1'b0;
  tsf_sample_s smp = '0;
  logic trig = 1'b0;
  wire cs, spc, sdi, sdi_en;
  logic sd_o, sd_oe, sd_spi, sd_spi_oe, serial_out_addr_lsb, sdo_oe, irq;
  // Two-wire pull-up on the shared line; data-out pin strapped high
  wire sda = sd_oe ? 1'b0 : (sd_spi_oe ? sd_spi : (sdi_en ? sdi : 1'b1));
  wire sdo_w = sdo_oe ? serial_out_addr_lsb : 1'b1;
  int err_count = 0;
  int checked = 0;
  logic [55:0] rd;
  logic [2:0] ack;

  tsf_sample_fifo uut (.core_clk_i(clk), .rstn_i(rstn), .sample_valid_i(valid),
    .sample_i(smp), .trigger_event_i(trig), .port_sel_i(cs), .serial_clk_i(spc),
    .serial_data_i(sda), .serial_out_addr_lsb_i(sdo_w), .serial_data_o(sd_o),
    .serial_data_oe_o(sd_oe), .serial_data_spi_o(sd_spi), .serial_data_spi_oe_o(sd_spi_oe),
    .serial_out_addr_lsb_o(serial_out_addr_lsb), .serial_out_addr_lsb_oe_o(sdo_oe),
    .ready_or_irq2_pin_o(irq));
  tsf_host_model host (.cs_o(cs), .spc_o(spc), .sdi_o(sdi), .sdi_en_o(sdi_en), .sdo_i(sdo_w),
    .sda_i(sda));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic tsf_sample_s mk(input logic [15:0] v);
    return {v + 16'h2000, v + 16'h1000, v};
  endfunction

  // Byte order of a six-byte burst from the X low register
  function automatic logic [47:0] order(input tsf_sample_s s);
    return {s.x[7:0], s.x[15:8], s.y[7:0], s.y[15:8], s.z[7:0], s.z[15:8]};
  endfunction

  // Gap after each frame covers the crossing into the core domain
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.frame(1'b0, a[5:0], 1, d, rd);
    repeat (10) @(negedge clk);
  endtask

  task automatic rdb(input logic [6:0] a, input int nb);
    host.frame(1'b1, a[5:0], nb, 8'h00, rd);
    repeat (10) @(negedge clk);
  endtask

  task automatic stat(input logic [7:0] mask, input logic [7:0] exp);
    rdb(ADDR_BUF_SOURCE, 1);
    check({40'h0, rd[7:0] & mask}, {40'h0, exp});
  endtask

  task automatic pin(input logic exp);
    check({47'h0, irq}, {47'h0, exp});
  endtask

  task automatic push(input logic [15:0] base, input int n);
    for (int i = 0; i < n; i++) begin
      @(negedge clk);
      valid = 1'b1;
      smp = mk(base + i[15:0]);
      @(negedge clk);
      valid = 1'b0;
    end
    repeat (4) @(negedge clk);
  endtask

  task automatic sets(input logic [15:0] base, input int n);
    for (int i = 0; i < n; i++) begin
      rdb(ADDR_OUT_X_L, 6);
      check(rd[47:0], order(mk(base + i[15:0])));
    end
  endtask

  task automatic fire();
    @(negedge clk);
    trig = 1'b1;
    @(negedge clk);
    trig = 1'b0;
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    err_count++;
    give_verdict();
  end

  initial begin
    repeat (16) @(negedge clk);
    rstn = 1'b1;
    repeat (4) @(negedge clk);
    stat(8'hff, 8'ha0);
    rdb(ADDR_BUF_CTRL, 1);
    check({40'h0, rd[7:0]}, {40'h0, BUF_CTRL_RST});
    rdb(ADDR_INT_PIN_CTRL, 1);
    check({40'h0, rd[7:0]}, {40'h0, INT_PIN_CTRL_RST});
    wr(ADDR_SERIAL_CFG, 8'h01);
    stat(8'hff, 8'ha0);
    wr(ADDR_SERIAL_CFG, 8'h00);
    $display("test reset done");

    host.i2c_wr({I2C_ADDR_HI, 1'b1}, {1'b0, ADDR_INT_PIN_CTRL}, 8'h01, ack);
    repeat (10) @(negedge clk);
    check({45'h0, ack}, 48'h0);
    pin(1'b1);
    push(16'h0100, 2);
    stat(8'hff, 8'ha0);
    rdb(ADDR_OUT_X_L, 7);
    check(rd[55:8], order(mk(16'h0101)));
    check({40'h0, rd[7:0]}, {40'h0, 8'h01});
    $display("test bypass done");

    wr(ADDR_BUF_CTRL, {MODE_FIFO, 5'h04});
    rdb(ADDR_BUF_CTRL, 1);
    check({40'h0, rd[7:0]}, {40'h0, 8'h24});
    push(16'h0200, 3);
    stat(8'he0, 8'h00);
    push(16'h0203, 1);
    stat(8'he0, 8'h80);
    pin(1'b0);
    wr(ADDR_INT_PIN_CTRL, 8'h04);
    pin(1'b1);
    wr(ADDR_INT_PIN_CTRL, 8'h00);
    pin(1'b0);
    push(16'h0204, 30);
    stat(8'he0, 8'hc0);
    wr(ADDR_INT_PIN_CTRL, 8'h02);
    pin(1'b1);
    sets(16'h0200, 32);
    stat(8'he0, 8'h20);
    $display("test fifo done");

    wr(ADDR_BUF_CTRL, {MODE_BYPASS, 5'h04});
    stat(8'he0, 8'h20);
    wr(ADDR_BUF_CTRL, {MODE_STREAM, 5'h04});
    push(16'h0300, 34);
    stat(8'he0, 8'hc0);
    sets(16'h0302, 32);
    $display("test stream done");

    wr(ADDR_BUF_CTRL, {MODE_BYPASS, 5'h04});
    wr(ADDR_BUF_CTRL, {MODE_STREAM_TO_FIFO, 5'h04});
    push(16'h0400, 34);
    fire();
    push(16'h0422, 3);
    sets(16'h0402, 32);
    $display("test stream to fifo done");

    wr(ADDR_BUF_CTRL, {MODE_BYPASS, 5'h04});
    wr(ADDR_BUF_CTRL, {MODE_BYPASS_TO_STREAM, 5'h04});
    push(16'h0500, 5);
    stat(8'he0, 8'h20);
    fire();
    push(16'h0505, 4);
    stat(8'he0, 8'h80);
    $display("test bypass to stream done");
    give_verdict();
  end
endmodule
